// File: core/add_accumulator_to_file_pkg.sv
package add_file_pkg;
  localparam logic [5:0]  OPCODE_ADD_W_F   = 6'h09;
  localparam int          OPCODE_MSB       = 15;
  localparam int          OPCODE_LSB       = 10;
  localparam int          DEST_BIT         = 9;
  localparam int          ACCESS_BIT       = 8;
  localparam logic [7:0]  INDEXED_LIMIT    = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
  localparam logic [5:0]  ACCESS_HIGH_BANK = 6'h3F;
  localparam logic [5:0]  BANK_RESET       = 6'h00;
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
  localparam int          FLAG_C           = 0;
  localparam int          FLAG_HALF_CARRY  = 1;
  localparam int          FLAG_Z           = 2;
  localparam int          FLAG_SIGNED_WRAP = 3;
  localparam int          FLAG_N           = 4;
  localparam logic [1:0]  PHASE_COUNT_LAST = 2'h3;
  localparam logic [11:0] APB_CTRL         = 12'h000;
  localparam logic [11:0] APB_INSTR        = 12'h004;
  localparam logic [11:0] APB_WREG         = 12'h008;
  localparam logic [11:0] APB_BANK         = 12'h00C;
  localparam logic [11:0] APB_STATUS       = 12'h010;
  localparam logic [11:0] APB_FSR2         = 12'h014;
  localparam logic [11:0] APB_FILE_ADDR    = 12'h018;
  localparam logic [11:0] APB_FILE_DATA    = 12'h01C;
  localparam int          CTRL_START       = 0;
  localparam int          CTRL_EXTENDED    = 1;
  localparam int          STAT_BUSY        = 8;
  localparam int          STAT_ILLEGAL     = 9;
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_type;
endpackage

// File: core/add_sum_unit.sv
`timescale 1ns/1ps
module add_sum_unit
  import add_file_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  output logic      [7:0] sum,
  output logic      [4:0] flags
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  always_comb begin
    low_sum  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full_sum = {1'b0, a} + {1'b0, b};
    sum      = full_sum[7:0];
    flags    = '0;
    flags[FLAG_C]  = full_sum[8];
    flags[FLAG_HALF_CARRY] = low_sum[4];
    flags[FLAG_Z]  = (full_sum[7:0] == BYTE_RESET);
    flags[FLAG_N]  = full_sum[7];
    // signed wrap: operands agree in sign, result does not
    flags[FLAG_SIGNED_WRAP] = (a[7] == b[7]) && (full_sum[7] != a[7]);
  end
endmodule

// File: core/add_accumulator_to_file.sv
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Contract
// - opcode 001001 adds working reg to file, sets flags
// - dest bit 0 writes working reg, else file
// - access bit 0 selects the access bank
// - access bit 1 uses bank select register
// - extended set, access 0, f<=5Fh: indexed offset
// - one word, one cycle: Q1..Q4 phases
module add_accumulator_to_file
  import add_file_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  logic [15:0] instr_q;
  logic [7:0]  wreg_q;
  logic [5:0]  bank_select_reg_q;
  logic [4:0]  flags_q;
  logic        extended_q;
  logic        busy_q;
  logic        illegal_q;
  logic [7:0]  fsr2_q;
  logic [13:0] file_addr_q;
  logic [7:0]  operand_q;
  logic [7:0]  result_q;
  logic [4:0]  result_flags_q;
  logic [13:0] target_q;
  logic        dest_file_q;
  logic        valid_q;
  phase_type   phase_q;
  logic [7:0]  ram [0:16383];
  logic [7:0]  sum;
  logic [4:0]  sum_flags;
  logic [13:0] target_d;
  logic        setup_ok;
  logic        wr_en;
  logic        rd_en;
  logic        addr_known;
  logic [31:0] rdata_d;
  logic [7:0]  file_offset;

  assign setup_ok    = psel && !penable;
  // writes land only at the completing access edge, never in setup
  assign wr_en       = psel && penable && pready && pwrite;
  assign rd_en       = setup_ok && !pwrite;
  assign file_offset = instr_q[7:0];

  add_sum_unit u_sum (
    .a     (wreg_q),
    .b     (operand_q),
    .sum   (sum),
    .flags (sum_flags)
  );

  // file address resolution
  always_comb begin
    if (instr_q[ACCESS_BIT]) begin
      target_d = {bank_select_reg_q, file_offset};
    end else if (extended_q && (file_offset <= INDEXED_LIMIT)) begin
      target_d = {6'h00, fsr2_q} + {6'h00, file_offset};
    end else if (file_offset < ACCESS_SPLIT) begin
      target_d = {BANK_RESET, file_offset};
    end else begin
      target_d = {ACCESS_HIGH_BANK, file_offset};
    end
  end

  always_comb begin
    addr_known = 1'b1;
    rdata_d    = '0;
    unique case (paddr)
      APB_CTRL:      rdata_d = {30'h0, extended_q, 1'b0};
      APB_INSTR:     rdata_d = {16'h0, instr_q};
      APB_WREG:      rdata_d = {24'h0, wreg_q};
      APB_BANK:      rdata_d = {26'h0, bank_select_reg_q};
      APB_STATUS:    rdata_d = {22'h0, illegal_q, busy_q, 3'h0, flags_q};
      APB_FSR2:      rdata_d = {24'h0, fsr2_q};
      APB_FILE_ADDR: rdata_d = {18'h0, file_addr_q};
      APB_FILE_DATA: rdata_d = {24'h0, ram[file_addr_q]};
      default:       addr_known = 1'b0;
    endcase
  end

  // zero-wait answer: pready rises in the first access-phase cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup_ok;
      pslverr <= setup_ok && !addr_known;
      prdata  <= rd_en ? rdata_d : '0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      extended_q        <= 1'b0;
      instr_q           <= '0;
      bank_select_reg_q <= BANK_RESET;
      fsr2_q            <= BYTE_RESET;
      file_addr_q       <= '0;
    end else if (wr_en && !busy_q) begin
      if (paddr == APB_CTRL) extended_q <= pwdata[CTRL_EXTENDED];
      if (paddr == APB_INSTR) instr_q <= pwdata[15:0];
      if (paddr == APB_BANK) bank_select_reg_q <= pwdata[5:0];
      if (paddr == APB_FSR2) fsr2_q <= pwdata[7:0];
      if (paddr == APB_FILE_ADDR) file_addr_q <= pwdata[13:0];
    end
  end

  // four-phase sequencer, started by software
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_q    <= 1'b0;
      phase_q   <= Q1;
      illegal_q <= 1'b0;
    end else if (!busy_q) begin
      if (wr_en && paddr == APB_CTRL && pwdata[CTRL_START]) begin
        busy_q    <= 1'b1;
        phase_q   <= Q1;
        illegal_q <= 1'b0;
      end
    end else begin
      unique case (phase_q)
        Q1: begin
          phase_q   <= Q2;
          illegal_q <= (instr_q[OPCODE_MSB:OPCODE_LSB] != OPCODE_ADD_W_F);
        end
        Q2: phase_q <= Q3;
        Q3: phase_q <= Q4;
        Q4: begin
          phase_q <= Q1;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // Q1 decode, Q2 read, Q3 compute
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      valid_q        <= 1'b0;
      dest_file_q    <= 1'b1;
      target_q       <= '0;
      operand_q      <= BYTE_RESET;
      result_q       <= BYTE_RESET;
      result_flags_q <= '0;
    end else if (busy_q) begin
      unique case (phase_q)
        Q1: begin
          valid_q     <= (instr_q[OPCODE_MSB:OPCODE_LSB] == OPCODE_ADD_W_F);
          dest_file_q <= instr_q[DEST_BIT];
          target_q    <= target_d;
        end
        Q2: operand_q <= ram[target_q];
        Q3: begin
          result_q       <= sum;
          result_flags_q <= sum_flags;
        end
        Q4: valid_q <= 1'b0;
      endcase
    end
  end

  // Q4 destination write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wreg_q  <= BYTE_RESET;
      flags_q <= '0;
    end else if (busy_q && phase_q == Q4 && valid_q) begin
      flags_q <= result_flags_q;
      if (!dest_file_q) wreg_q <= result_q;
    end else if (wr_en && !busy_q && paddr == APB_WREG) begin
      wreg_q <= pwdata[7:0];
    end
  end

  // no reset on the ram array: keeps it inferable as memory
  always_ff @(posedge clk_sys) begin
    if (busy_q && phase_q == Q4 && valid_q && dest_file_q) begin
      ram[target_q] <= result_q;
    end else if (wr_en && !busy_q && paddr == APB_FILE_DATA) begin
      ram[file_addr_q] <= pwdata[7:0];
    end
  end
endmodule

// File: testbench/add_file_props.sv
`timescale 1ns/1ps
module add_file_props (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("data off");
  write_data_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("data on write");
  // unmapped space starts past the last word
  bad_addr_a: assert property (psel && !penable && paddr > 12'h01C |=> pslverr) else $error("no error");
  good_addr_a: assert property (psel && !penable && paddr < 12'h020 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("false error");
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import add_file_pkg::*;
  logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, seed;
  int          error_cnt, comparisons;
  add_accumulator_to_file dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #12.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [4:0] flags(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    s = x + y;
    return {s[7], x[7] == y[7] && s[7] != x[7], s[7:0] == 8'h00, x[3:0] + y[3:0] > 5'h0F, s[8]};
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // an idle edge before each setup keeps every strobe to one assignment per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [15:0] ins, input logic x);
    int n;
    apb(1'b1, APB_INSTR, {16'h0, ins});
    apb(1'b1, APB_CTRL, {30'h0, x, 1'b1});
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (rv[STAT_BUSY] !== 1'b0 && n < 20);
    chk(n <= 2, 1);
  endtask
  initial begin
    logic [31:0] r, q;
    logic [13:0] fa;
    logic [8:0]  s;
    logic [7:0]  f, lw;
    clk_sys = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'd58764;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(1'b0, APB_WREG, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, APB_STATUS, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(ev, 1);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      q = rnd();
      if (i == 0) begin
        r[15:0] = 16'hC217;
        q[14:12] = 3'h0;
      end
      if (i == 1)
        r[15:0] = 16'h8080;
      f = r[23:16];
      fa = q[13] ? {r[29:24], f} : (q[14] && f <= INDEXED_LIMIT) ? {6'h00, q[7:0]} + f :
        {f < ACCESS_SPLIT ? BANK_RESET : ACCESS_HIGH_BANK, f};
      apb(1'b1, APB_FILE_ADDR, {18'h0, fa});
      apb(1'b1, APB_FILE_DATA, r[15:8]);
      apb(1'b1, APB_WREG, r[7:0]);
      apb(1'b1, APB_BANK, r[29:24]);
      apb(1'b1, APB_FSR2, q[11:0]);
      go({OPCODE_ADD_W_F, q[12], q[13], f}, q[14]);
      s = r[7:0] + r[15:8];
      lw = q[12] ? r[7:0] : s[7:0];
      apb(1'b0, APB_WREG, 32'h0);
      chk(rv, lw);
      apb(1'b0, APB_FILE_DATA, 32'h0);
      chk(rv, q[12] ? s[7:0] : r[15:8]);
      apb(1'b0, APB_STATUS, 32'h0);
      chk(rv, flags(r[7:0], r[15:8]));
      $display("test %0d done", i);
    end
    go({6'h0A, 10'h000}, 1'b0);
    apb(1'b0, APB_WREG, 32'h0);
    chk(rv, lw);
    apb(1'b0, APB_STATUS, 32'h0);
    chk(rv, 32'h200 | flags(r[7:0], r[15:8]));
    $display("test illegal done");
    print_verdict();
  end
endmodule
bind add_accumulator_to_file add_file_props props (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
